// *** verilog/tcs_defs.svh ***
// Register offsets, reset values, scaling and timing constants
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

`define TCS_OFS_CTRL      8'h00
`define TCS_OFS_IOCFG     8'h04
`define TCS_OFS_SWTGT     8'h08
`define TCS_OFS_STATUS    8'h0c
`define TCS_OFS_TARGET    8'h10
`define TCS_OFS_IRQSTAT   8'h14
`define TCS_OFS_IRQMASK   8'h18

`define TCS_CTRL_W        4
`define TCS_IOCFG_W       6
`define TCS_IRQ_W         4
`define TCS_CTRL_RST      4'h0
`define TCS_IOCFG_RST     6'h00
`define TCS_SWTGT_RST     16'h00fa
`define TCS_IRQMASK_RST   4'h0

`define TCS_CLK_NS        25
`define TCS_BOOT_NS       100000
`define TCS_BOOT_CYC      ((`TCS_BOOT_NS + `TCS_CLK_NS - 1) / `TCS_CLK_NS)

`define TCS_TMIN          (-1000)
`define TCS_TSPAN         3000
`define TCS_TMAX          2000
`define TCS_WIN           10
`define TCS_CODE_MAX      4095
`define TCS_DAC_ZERO      12'h555

`endif

// *** verilog/tcs_pkg.sv ***
// Types shared by the thermo controller supervisor
`default_nettype none
package tcs_pkg;
  typedef enum logic [1:0] {TCS_BOOT, TCS_RDY, TCS_ERR} tcs_state_e;
  typedef struct packed {
    logic stat_oc;
    logic stat_low;
    logic rdy_oc;
    logic rdy_low;
    logic clr_high;
    logic run_high;
  } tcs_iocfg_s;
  typedef struct packed {
    logic err_clr;
    logic sw_run;
    logic sp_sw;
    logic run_sw;
  } tcs_ctrl_s;
  typedef struct packed {
    logic win_left;
    logic win_ent;
    logic err_clr;
    logic err_ent;
  } tcs_irq_s;
  typedef logic signed [15:0] tcs_temp_t;
endpackage : tcs_pkg
`default_nettype wire

// *** verilog/tcs_pin_sync.sv ***
// Two-stage pin synchroniser with selectable active level
`timescale 1ns/100ps
`default_nettype none
module tcs_pin_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic pin,
  input  wire logic act_high,
  output logic      active
);
  logic sync1_q;
  logic sync2_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else if (ce) begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
    end
  end

  // Polarity is applied after the second stage only
  assign active = act_high ? sync2_q : ~sync2_q;
endmodule : tcs_pin_sync
`default_nettype wire

// *** verilog/tcs_supervisor.sv ***
// Supervisory control, pin handling and APB registers of the cooler controller
// What this block does
// - Open or shorted sensor forces the error state and stops regulation.
// - Hardware setpoint maps analog code 0..5 V onto -100..+200 degrees C.
// - Temperature output code is linear over 0..5 V, 1.67 V at 0 degrees C.
// - Run and clear input polarities set separately; both default low-active.
// - Active run input enables power stage and closed-loop regulation.
// - Clear input clears internal error states, not the processor.
// - Each status output has own polarity and drive type; default high push-pull.
// - Readiness output rises once operational, falls on any internal error.
// - In-window output only while enabled and within 1 degree of setpoint.
// - Software run source still needs the hardware run input active.
// - Software setpoint mode takes host target and ignores the analog input.
// - Host software may also request error clear.
// - One command path regardless of USB or RS232 link variant.
`include "tcs_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tcs_supervisor
  import tcs_pkg::*;
#(
  parameter int BOOT_CYCLES = `TCS_BOOT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hardware_run_input,
  input  wire logic        error_clear_input,
  input  wire logic        sensor_open,
  input  wire logic        sensor_short,
  input  wire logic [11:0] analog_target_input,
  input  wire tcs_temp_t   meas_temp,
  output logic             regulate_en,
  output tcs_temp_t        target_temp,
  output logic      [11:0] temp_dac,
  output logic             ready_out,
  output logic             ready_oe,
  output logic             status_out,
  output logic             status_oe,
  output logic             irq
);
  tcs_state_e  state_q;
  tcs_state_e  state_d;
  tcs_ctrl_s   ctrl_q;
  tcs_iocfg_s  cfg_q;
  tcs_temp_t   sw_tgt_q;
  tcs_irq_s    irq_stat_q;
  tcs_irq_s    irq_stat_d;
  tcs_irq_s    irq_mask_q;
  tcs_irq_s    irq_set;
  logic [11:0] boot_cnt_q;
  logic        in_win_q;
  logic        in_win_d;
  logic        run_act;
  logic        clr_act;
  logic        open_act;
  logic        short_act;
  logic        fault;
  logic        acc;
  logic        done;
  logic        hit;
  logic        wr_ctrl;
  logic        sw_clr;
  logic        clr_req;
  logic        run_d;
  logic        rd_irq;

  // Converts an analog setpoint code to tenths of a degree, rounded
  function automatic tcs_temp_t code_to_temp(input logic [11:0] c);
    int v;
    v = (int'(c) * `TCS_TSPAN + `TCS_CODE_MAX / 2) / `TCS_CODE_MAX + `TCS_TMIN;
    return tcs_temp_t'(v);
  endfunction : code_to_temp

  // Converts a temperature in tenths of a degree to an output code, clamped
  function automatic logic [11:0] temp_to_code(input tcs_temp_t t);
    int v;
    v = 0;
    if (int'(t) <= `TCS_TMIN) v = 0;
    else if (int'(t) >= `TCS_TMAX) v = `TCS_CODE_MAX;
    else v = ((int'(t) - `TCS_TMIN) * `TCS_CODE_MAX + `TCS_TSPAN / 2) / `TCS_TSPAN;
    return 12'(v);
  endfunction : temp_to_code

  // Pin level for an indication, given active-low choice
  function automatic logic [1:0] drive(input logic on, input logic low, input logic oc);
    logic lvl;
    lvl = on ^ low;
    // Open collector can only pull low, so it releases for a high level
    return oc ? {1'b0, ~lvl} : {lvl, 1'b1};
  endfunction : drive

  tcs_pin_sync u_run (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .pin      (hardware_run_input),
    .act_high (cfg_q.run_high),
    .active   (run_act)
  );
  tcs_pin_sync u_clr (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .pin      (error_clear_input),
    .act_high (cfg_q.clr_high),
    .active   (clr_act)
  );
  tcs_pin_sync u_open (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .pin      (sensor_open),
    .act_high (1'b1),
    .active   (open_act)
  );
  tcs_pin_sync u_short (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .pin      (sensor_short),
    .act_high (1'b1),
    .active   (short_act)
  );

  assign fault = open_act | short_act;

  // APB slave: one wait state, so every output is a flop
  assign acc = psel & penable;
  assign done = acc & pready;
  assign hit = (paddr[1:0] == 2'b00) && (paddr <= `TCS_OFS_IRQMASK);
  // The host link variant only changes the physical layer; one register map
  assign wr_ctrl = done & pwrite & (paddr == `TCS_OFS_CTRL);
  assign sw_clr = wr_ctrl & pwdata[`TCS_CTRL_W-1];
  assign clr_req = clr_act | sw_clr;
  assign rd_irq = done & ~pwrite & (paddr == `TCS_OFS_IRQSTAT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (ce) begin
      pready <= acc & ~pready;
      if (acc & ~pready) begin
        pslverr <= ~hit;
        case (paddr)
          `TCS_OFS_CTRL:    prdata <= {29'h0, ctrl_q.sw_run, ctrl_q.sp_sw, ctrl_q.run_sw};
          `TCS_OFS_IOCFG:   prdata <= {26'h0, cfg_q};
          `TCS_OFS_SWTGT:   prdata <= {{16{sw_tgt_q[15]}}, sw_tgt_q};
          `TCS_OFS_STATUS:  prdata <= {25'h0, run_act, regulate_en, short_act, open_act,
                                       state_q == TCS_ERR, in_win_q, state_q == TCS_RDY};
          `TCS_OFS_TARGET:  prdata <= {{16{target_temp[15]}}, target_temp};
          `TCS_OFS_IRQSTAT: prdata <= {28'h0, irq_stat_q};
          `TCS_OFS_IRQMASK: prdata <= {28'h0, irq_mask_q};
          default:          prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `TCS_CTRL_RST;
      cfg_q <= `TCS_IOCFG_RST;
      sw_tgt_q <= `TCS_SWTGT_RST;
      irq_mask_q <= `TCS_IRQMASK_RST;
    end else if (ce && done && pwrite) begin
      case (paddr)
        `TCS_OFS_CTRL:    ctrl_q <= {1'b0, pwdata[`TCS_CTRL_W-2:0]};
        `TCS_OFS_IOCFG:   cfg_q <= pwdata[`TCS_IOCFG_W-1:0];
        `TCS_OFS_SWTGT:   sw_tgt_q <= pwdata[15:0];
        `TCS_OFS_IRQMASK: irq_mask_q <= pwdata[`TCS_IRQ_W-1:0];
        default:          ;
      endcase
    end
  end

  // Supervisory state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      TCS_BOOT: if (32'(boot_cnt_q) >= BOOT_CYCLES - 1) state_d = fault ? TCS_ERR : TCS_RDY;
      TCS_RDY:  if (fault) state_d = TCS_ERR;
      // A clear while the fault persists is lost: the fault wins
      TCS_ERR:  if (clr_req && !fault) state_d = TCS_RDY;
      default:  state_d = TCS_BOOT;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= TCS_BOOT;
      boot_cnt_q <= 12'h000;
    end else if (ce) begin
      state_q <= state_d;
      if (state_q == TCS_BOOT) boot_cnt_q <= boot_cnt_q + 12'h001;
    end
  end

  // Regulation needs the hardware run input in both run sources
  assign run_d = (state_q == TCS_RDY) && !fault && run_act
                 && (!ctrl_q.run_sw || ctrl_q.sw_run);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regulate_en <= 1'b0;
      target_temp <= 16'h0000;
      temp_dac <= 12'h000;
    end else if (ce) begin
      regulate_en <= run_d;
      target_temp <= ctrl_q.sp_sw ? sw_tgt_q
                                  : code_to_temp(analog_target_input);
      temp_dac <= temp_to_code(meas_temp);
    end
  end

  // Window compare uses a wide difference so extremes cannot wrap
  always_comb begin
    int diff;
    diff = int'(meas_temp) - int'(target_temp);
    in_win_d = regulate_en && diff <= `TCS_WIN && diff >= -`TCS_WIN;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_win_q <= 1'b0;
      ready_out <= 1'b0;
      ready_oe <= 1'b1;
      status_out <= 1'b0;
      status_oe <= 1'b1;
    end else if (ce) begin
      in_win_q <= in_win_d;
      {ready_out, ready_oe} <= drive(state_q == TCS_RDY, cfg_q.rdy_low, cfg_q.rdy_oc);
      {status_out, status_oe} <= drive(in_win_q, cfg_q.stat_low, cfg_q.stat_oc);
    end
  end

  // Sticky events; a read clears only the bits it returned, so a newer event survives
  assign irq_set.err_ent = (state_d == TCS_ERR) && (state_q != TCS_ERR);
  assign irq_set.err_clr = (state_d == TCS_RDY) && (state_q == TCS_ERR);
  assign irq_set.win_ent = in_win_d & ~in_win_q;
  assign irq_set.win_left = ~in_win_d & in_win_q;
  assign irq_stat_d = (irq_stat_q & ~(rd_irq ? prdata[`TCS_IRQ_W-1:0] : 4'h0)) | irq_set;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= 4'h0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_stat_q <= irq_stat_d;
      irq <= |(irq_stat_d & irq_mask_q);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  AST_FAULT_STOPS: assert property (
    state_q == TCS_RDY && fault |=> state_q == TCS_ERR && !regulate_en)
    else $error("fault did not enter error state");
  AST_SETPOINT_MAP: assert property (
    !ctrl_q.sp_sw && analog_target_input == 12'hfff |=> target_temp == 16'sd2000)
    else $error("full-scale setpoint not mapped to 200 degrees");
  AST_DAC_ZERO: assert property (
    meas_temp == 16'h0000 |=> temp_dac == `TCS_DAC_ZERO)
    else $error("zero degrees not at 1.67 V code");
  AST_RUN_POLARITY: assert property (
    $stable(cfg_q.run_high) && $past(ce) && $past(ce, 2) && !$past(rst) && !$past(rst, 2)
    |-> run_act == ($past(hardware_run_input, 2) ~^ cfg_q.run_high))
    else $error("run input polarity wrong");
  AST_RUN_ENABLE: assert property (
    state_q == TCS_RDY && !fault && run_act && !ctrl_q.run_sw |=> regulate_en)
    else $error("regulation not enabled by run input");
  AST_HW_CLEAR: assert property (
    state_q == TCS_ERR && clr_act && !fault |=> state_q == TCS_RDY)
    else $error("hardware clear ignored");
  AST_PUSH_PULL: assert property (
    !cfg_q.rdy_oc && !cfg_q.rdy_low && state_q == TCS_RDY |=> ready_oe && ready_out)
    else $error("ready push-pull drive wrong");
  AST_READY_DROP: assert property (
    state_q == TCS_ERR && !cfg_q.rdy_low && !cfg_q.rdy_oc |=> !ready_out)
    else $error("ready asserted in error");
  AST_WINDOW: assert property (
    in_win_q |-> $past(regulate_en))
    else $error("in-window without regulation");
  AST_SW_NEEDS_HW: assert property (
    !run_act |=> !regulate_en)
    else $error("regulation without hardware run input");
  AST_SW_TARGET: assert property (
    ctrl_q.sp_sw |=> target_temp == $past(sw_tgt_q))
    else $error("software target not used");
  AST_SW_CLEAR: assert property (
    state_q == TCS_ERR && sw_clr && !fault |=> state_q == TCS_RDY)
    else $error("software clear ignored");
  AST_ERR_LATCH: assert property (
    state_q == TCS_ERR && !clr_req |=> state_q == TCS_ERR ##0 !regulate_en)
    else $error("error state left without clear");

  COV_ERR_ENTER: cover property (state_q == TCS_RDY ##1 state_q == TCS_ERR);
  COV_ERR_CLEAR: cover property (state_q == TCS_ERR ##1 state_q == TCS_RDY);
  COV_IN_WINDOW: cover property (regulate_en ##1 in_win_q);
  COV_IRQ: cover property (irq ##1 rd_irq);
endmodule : tcs_supervisor
`default_nettype wire

// *** tb/tcs_far_side.sv ***
// Far-side model: run and clear switches and pulled-up loads on the status pins
`timescale 1ns/100ps
`default_nettype none
module tcs_far_side (
  input  wire logic run_on,
  input  wire logic clr_on,
  input  wire logic run_high,
  input  wire logic clr_high,
  input  wire logic rdy_out,
  input  wire logic rdy_oe,
  input  wire logic st_out,
  input  wire logic st_oe,
  output logic      run_pin,
  output logic      clr_pin,
  output logic      rdy_lvl,
  output logic      st_lvl
);
  // Operator keeps the run switch closed even when software owns the run source
  assign run_pin = run_on ~^ run_high;
  assign clr_pin = clr_on ~^ clr_high;
  // Load pull-up takes a released open-collector pin high, never a stale level
  assign rdy_lvl = rdy_oe ? rdy_out : 1'b1;
  assign st_lvl  = st_oe ? st_out : 1'b1;
endmodule : tcs_far_side
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the thermo controller supervisor
`include "tcs_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import tcs_pkg::*;
();
  localparam int BOOT = 8;
  localparam int RUN = 0;
  localparam int CLR = 1;
  localparam int OPN = 2;
  localparam int SHT = 3;
  logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic run_on, clr_on, run_pin, clr_pin, sensor_open, sensor_short;
  logic [11:0] analog_target_input, temp_dac, c;
  tcs_temp_t meas_temp, target_temp, tt;
  logic regulate_en, ready_out, ready_oe, status_out, status_oe, irq, rdy_lvl, st_lvl;
  tcs_iocfg_s cfg;
  int seed, n_mismatch, n_checks, cyc, t;
  int tdac[4] = '{0, -1000, 2000, -1500};
  int dw[5] = '{-11, -10, 0, 10, 11};

  tcs_supervisor #(.BOOT_CYCLES(BOOT)) dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hardware_run_input(run_pin),
    .error_clear_input(clr_pin), .sensor_open(sensor_open), .sensor_short(sensor_short),
    .analog_target_input(analog_target_input), .meas_temp(meas_temp),
    .regulate_en(regulate_en), .target_temp(target_temp), .temp_dac(temp_dac),
    .ready_out(ready_out), .ready_oe(ready_oe), .status_out(status_out),
    .status_oe(status_oe), .irq(irq));
  tcs_far_side far (.run_on(run_on), .clr_on(clr_on), .run_high(cfg.run_high),
    .clr_high(cfg.clr_high), .rdy_out(ready_out), .rdy_oe(ready_oe), .st_out(status_out),
    .st_oe(status_oe), .run_pin(run_pin), .clr_pin(clr_pin), .rdy_lvl(rdy_lvl),
    .st_lvl(st_lvl));

  always #12.5 clk = ~clk;

  function automatic tcs_temp_t exp_sp(input logic [11:0] k);
    return tcs_temp_t'((int'(k) * 3000 + 2047) / 4095 - 1000);
  endfunction : exp_sp

  function automatic logic [11:0] exp_dac(input int v);
    int r;
    r = ((v + 1000) * 4095 + 1500) / 3000;
    return (v < -1000) ? 12'h000 : (r > 4095) ? 12'hfff : r[11:0];
  endfunction : exp_dac

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Sits at a falling edge between actions so every drive lands on a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr && a == `TCS_OFS_IOCFG) cfg <= tcs_iocfg_s'(d[5:0]);
    @(negedge clk);
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(q, x);
  endtask : rdc

  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    settle(4);
  endtask : wrr

  // Switch or sensor pin by index: run, clear, open sensor, shorted sensor
  task automatic pin(input int k, input logic v);
    @(posedge clk);
    case (k)
      RUN: run_on <= v;
      CLR: clr_on <= v;
      OPN: sensor_open <= v;
      default: sensor_short <= v;
    endcase
    settle(6);
  endtask : pin

  task automatic set_sp(input logic [11:0] v, input int n);
    @(posedge clk);
    analog_target_input <= v;
    settle(n);
  endtask : set_sp

  task automatic set_mt(input int v, input int n);
    @(posedge clk);
    meas_temp <= tcs_temp_t'(v);
    settle(n);
  endtask : set_mt

  task final_report;
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  // Ceiling well above the several hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      final_report;
    end
  end

  initial begin
    seed = 71;
    clk = 0;
    rst = 1;
    ce = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run_on = 0;
    clr_on = 0;
    sensor_open = 0;
    sensor_short = 0;
    analog_target_input = 12'h000;
    meas_temp = 16'sh0000;
    cfg = '0;
    cyc = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    settle(BOOT + 6);
    check(ready_out, 1'b1);
    check(rdy_lvl, 1'b1);
    rdc(`TCS_OFS_CTRL, 32'h0);
    rdc(`TCS_OFS_IOCFG, 32'h0);
    rdc(`TCS_OFS_SWTGT, 32'h0000_00fa);
    rdc(`TCS_OFS_IRQMASK, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    check({q[30:0], e}, 32'h1);
    $display("Test registers done");
    pin(RUN, 1'b1);
    check(regulate_en, 1'b1);
    wrr(`TCS_OFS_CTRL, 32'h1);
    check(regulate_en, 1'b0);
    wrr(`TCS_OFS_CTRL, 32'h5);
    check(regulate_en, 1'b1);
    wrr(`TCS_OFS_CTRL, 32'h0);
    wrr(`TCS_OFS_IOCFG, 32'h1);
    settle(4);
    check(regulate_en, 1'b1);
    pin(RUN, 1'b0);
    check(regulate_en, 1'b0);
    pin(RUN, 1'b1);
    $display("Test run done");
    for (int i = 0; i < 10; i++) begin
      c = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($random(seed));
      set_sp(c, 3);
      check(target_temp, exp_sp(c));
    end
    tt = tcs_temp_t'($random(seed) & 32'h7ff) - 16'sd500;
    wrr(`TCS_OFS_SWTGT, {{16{tt[15]}}, tt});
    wrr(`TCS_OFS_CTRL, 32'h2);
    set_sp(12'h800, 6);
    check(target_temp, tt);
    rdc(`TCS_OFS_TARGET, {{16{tt[15]}}, tt});
    wrr(`TCS_OFS_CTRL, 32'h0);
    $display("Test setpoint done");
    for (int i = 0; i < 10; i++) begin
      t = (i < 4) ? tdac[i] : (($random(seed) & 32'hfff) - 1000);
      set_mt(t, 3);
      check(temp_dac, exp_dac(t));
    end
    $display("Test output code done");
    set_sp(12'h000, 6);
    foreach (dw[i]) begin
      set_mt(dw[i] - 1000, 6);
      check(status_out, dw[i] <= 10 && dw[i] >= -10);
    end
    set_mt(-1000, 6);
    check(status_out, 1'b1);
    pin(RUN, 1'b0);
    check(status_out, 1'b0);
    pin(RUN, 1'b1);
    $display("Test window done");
    wrr(`TCS_OFS_IRQMASK, 32'hf);
    apb(1'b0, `TCS_OFS_IRQSTAT, 32'h0);
    pin(OPN, 1'b1);
    check({regulate_en, ready_out, irq}, 3'b001);
    rdc(`TCS_OFS_STATUS, 32'h4c);
    apb(1'b0, `TCS_OFS_IRQSTAT, 32'h0);
    check(q[0], 1'b1);
    settle(2);
    rdc(`TCS_OFS_IRQSTAT, 32'h0);
    check(irq, 1'b0);
    pin(CLR, 1'b1);
    pin(CLR, 1'b0);
    check(ready_out, 1'b0);
    pin(OPN, 1'b0);
    check({regulate_en, ready_out}, 2'b00);
    pin(CLR, 1'b1);
    pin(CLR, 1'b0);
    check({regulate_en, ready_out}, 2'b11);
    apb(1'b0, `TCS_OFS_IRQSTAT, 32'h0);
    check(q[1], 1'b1);
    pin(SHT, 1'b1);
    check({regulate_en, ready_out}, 2'b00);
    pin(SHT, 1'b0);
    wrr(`TCS_OFS_CTRL, 32'h8);
    check(ready_out, 1'b1);
    wrr(`TCS_OFS_IOCFG, 32'h3);
    pin(SHT, 1'b1);
    pin(SHT, 1'b0);
    pin(CLR, 1'b1);
    pin(CLR, 1'b0);
    check(ready_out, 1'b1);
    $display("Test fault done");
    wrr(`TCS_OFS_IOCFG, 32'h0d);
    check({ready_oe, rdy_lvl}, 2'b10);
    wrr(`TCS_OFS_IOCFG, 32'h05);
    check({ready_oe, ready_out}, 2'b10);
    wrr(`TCS_OFS_IOCFG, 32'h21);
    check({status_oe, st_lvl}, 2'b01);
    wrr(`TCS_OFS_IOCFG, 32'h11);
    check({status_oe, status_out}, 2'b10);
    $display("Test pin config done");
    // A fault that arrives while the clock enable is low must wait for it
    @(posedge clk);
    ce <= 1'b0;
    sensor_open <= 1'b1;
    settle(6);
    check({regulate_en, ready_out}, 2'b11);
    @(posedge clk);
    ce <= 1'b1;
    settle(6);
    check({regulate_en, ready_out}, 2'b00);
    pin(OPN, 1'b0);
    pin(CLR, 1'b1);
    pin(CLR, 1'b0);
    check({regulate_en, ready_out}, 2'b11);
    $display("Test clock enable done");
    final_report;
  end
endmodule : tb_top
`default_nettype wire
